/* File: hw/emi_pkg.sv */
// emi_pkg: constants, codes and carriers of the enclave measure/init block
// ==========================================================================
// Contract
// R1 - measure-extend faults (general protection) if control address not 4096-aligned
// R2 - measure-extend faults (general protection) if chunk address not 256-aligned
// R3 - page fault if chunk outside page cache or its map entry invalid
// R4 - page fault unless chunk page type is regular, thread or shadow stack
// R5 - general protection fault while another operation uses map, measurement or init
// R6 - general protection fault if operand_b is not the chunk owner's control
// R7 - hash header block with tag and enclave offset, then count one update
// R8 - hash chunk as four ascending 64-byte blocks, then count four updates
// R9 - measure-extend faults (general protection) if enclave already initialized
// R10 - general protection fault on non-canonical or out-of-limit operand address
// R11 - enclave-init is leaf 02H; operands b, c, d hold its structures
// R12 - enclave-init verifies signature with embedded 3072-bit key and q1, q2
// R13 - finalized measurement must equal signature hash, else measurement error
// R14 - reject reserved attribute bits set, or reserved mask bits cleared
// R15 - controlled attributes need signer digest equal to launch_key_hash_reg
// R16 - signature attributes must equal mask AND control attributes
// R17 - token invalid: signer digest must equal launch_key_hash_reg
// R18 - token valid: token checked, measurement matches, debug token needs debug
// R19 - success commits measurement, signer, version, product id, initialized
// R20 - uninhibited events during init end with unmasked-event error, pointer advances
// R21 - init clears arithmetic flags; zero flag and result report outcome
// R22 - init reports distinct codes for each failure kind
// R23 - measure-extend only at privilege level 0 on uninitialized enclave
// R24 - any fault or error leaves measurement, counter and initialized untouched
package emi_pkg;
  // ========================================================================
  // leaf codes and constants
  localparam logic [63:0] EMI_LEAF_INIT = 64'h0000_0000_0000_0002;
  localparam logic [63:0] EMI_LEAF_EXTEND = 64'h0000_0000_0000_0006; // leaf value arbitrary
  localparam logic [63:0] EMI_EXT_TAG = 64'h0044_4e45_5458_4545;
  localparam logic [63:0] EMI_ENCLAVE_CONTROL_STRUCTURE_ALIGN = 64'h0000_0000_0000_0fff;
  localparam logic [63:0] EMI_CHUNK_ALIGN = 64'h0000_0000_0000_00ff;
  localparam logic [63:0] EMI_PAGE_OFS = 64'h0000_0000_0000_0fff;
  localparam logic [63:0] EMI_HDR_INC = 64'h0000_0000_0000_0001;
  localparam logic [63:0] EMI_CHUNK_INC = 64'h0000_0000_0000_0004;
  localparam logic [1:0] EMI_LAST_BLK = 2'h3;
  localparam logic [1:0] EMI_CPL0 = 2'h0;
  localparam logic [127:0] EMI_CTRL_ATTR = 128'h0000_0000_0000_0000_0000_0000_0000_0020;
  localparam logic [127:0] EMI_ATTR_RSVD = 128'hffff_ffff_ffff_ff00_ffff_ffff_ffff_ffc8;
  localparam int EMI_DEBUG_BIT = 1;
  // page types, values arbitrary
  localparam logic [7:0] EMI_PT_REGULAR = 8'h01;
  localparam logic [7:0] EMI_PT_THREAD = 8'h02;
  localparam logic [7:0] EMI_SHADOW_STACK_FIRST_TYPE = 8'h05;
  localparam logic [7:0] EMI_SHADOW_STACK_REST_TYPE = 8'h06;
  // error codes, values arbitrary but distinct
  localparam logic [63:0] EMI_ERR_NONE = 64'h0000_0000_0000_0000;
  localparam logic [63:0] EMI_ERR_STRUCT = 64'h0000_0000_0000_0001;
  localparam logic [63:0] EMI_ERR_ATTR = 64'h0000_0000_0000_0002;
  localparam logic [63:0] EMI_ERR_MEAS = 64'h0000_0000_0000_0003;
  localparam logic [63:0] EMI_ERR_SIG = 64'h0000_0000_0000_0004;
  localparam logic [63:0] EMI_ERR_LICENSE = 64'h0000_0000_0000_0005;
  localparam logic [63:0] EMI_ERR_VERSION = 64'h0000_0000_0000_0006;
  localparam logic [63:0] EMI_ERR_EVENT = 64'h0000_0000_0000_0007;

  // ========================================================================
  // carriers
  typedef struct packed {
    logic [63:0] leaf;    // result_reg on entry
    logic [63:0] op_b;
    logic [63:0] op_c;
    logic [63:0] op_d;
    logic [1:0] cpl;
    logic addr_ok;        // canonical (64-bit) or inside limit (protected)
    logic busy_map;       // another op on page_cache_map
    logic busy_meas;      // another op on enclave_measurement
    logic busy_init;      // another op on initialized state
  } emi_req_s;

  typedef struct packed {
    logic in_cache;       // chunk inside protected_page_cache
    logic valid;
    logic [7:0] ptype;
    logic [63:0] owner;   // control structure owning the page
    logic [63:0] encl_addr;
    logic [63:0] enclave_control_structure_base;
    logic [127:0] enclave_control_structure_attr;
  } emi_page_s;

  typedef struct packed {
    logic struct_ok;      // header fields and reserved space fine
    logic [127:0] attr;
    logic [127:0] mask;
    logic [255:0] hash;
    logic [15:0] svn;
    logic [15:0] prodid;
    logic tok_valid;
    logic tok_ok;         // token reserved space and mac fine
    logic tok_ver_ok;     // token version supported
    logic tok_debug;
    logic [255:0] tok_meas;
  } emi_init_s;

  typedef struct packed {
    logic sig_ok;         // 3072-bit key check with q1, q2
    logic [255:0] final_meas;
    logic [255:0] signer;  // digest of signer modulus
  } emi_crypto_s;
endpackage

/* File: hw/emi_core.sv */
// emi_core: measure-extend and enclave-init sequencer
`timescale 1ns/10ps
module emi_core
  import emi_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic OP_START,
  input wire emi_req_s OP_REQ,
  input wire emi_page_s PAGE,
  input wire emi_init_s INIT_IN,
  input wire logic [2047:0] CHUNK,
  input wire logic [255:0] LAUNCH_KEY_HASH,
  input wire logic [5:0] EVENT_PENDING,
  input wire logic [5:0] EVENT_INHIBIT,
  input wire logic HASH_READY,
  input wire logic CRYPTO_DONE,
  input wire emi_crypto_s CRYPTO,
  output logic BUSY,
  output logic OP_DONE,
  output logic GP_FAULT,
  output logic PF_FAULT,
  output logic [63:0] PF_ADDR,
  output logic [63:0] RESULT,
  output logic ZERO_FLAG,
  output logic ARITH_CLEAR,
  output logic IP_ADVANCE,
  output logic HASH_VALID,
  output logic [511:0] HASH_BLOCK,
  output logic CRYPTO_REQ,
  output logic MEAS_COMMIT,
  output logic INITIALIZED,
  output logic [63:0] UPDATE_COUNT,
  output logic [255:0] SIGNER,
  output logic [15:0] SVN,
  output logic [15:0] PRODID
);
  // ========================================================================
  // state machine
  typedef enum logic [2:0] {
    EMI_IDLE = 3'h0,
    EMI_HDR = 3'h1,
    EMI_BLK = 3'h3,
    EMI_INIT = 3'h2,
    EMI_FIN = 3'h6
  } emi_state_e;

  emi_state_e state;
  emi_state_e next_state;
  logic [1:0] blk;
  emi_req_s req;
  logic [63:0] next_code;
  logic next_gp;
  logic next_pf;
  logic [63:0] next_pf_addr;
  logic next_err;

  function automatic logic misaligned(input logic [63:0] a, input logic [63:0] m);
    return (a & m) != 64'h0;
  endfunction

  function automatic logic attr_mismatch(input logic [127:0] a, input logic [127:0] b);
    return a != b;
  endfunction

  // latch the request so callers need not hold it
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      req <= '0;
    end else if (state == EMI_IDLE && OP_START) begin
      req <= OP_REQ;
    end
  end

  // ========================================================================
  // entry checks for measure-extend, in documented priority order
  logic ext_gp;
  logic ext_pf;
  always_comb begin
    ext_gp = 1'b0;
    ext_pf = 1'b0;
    if (!OP_REQ.addr_ok) begin
      ext_gp = 1'b1; // R10
    end else if (OP_REQ.cpl != EMI_CPL0) begin
      ext_gp = 1'b1; // R23
    end else if (misaligned(OP_REQ.op_b, EMI_ENCLAVE_CONTROL_STRUCTURE_ALIGN)) begin
      ext_gp = 1'b1; // R1
    end else if (misaligned(OP_REQ.op_c, EMI_CHUNK_ALIGN)) begin
      ext_gp = 1'b1; // R2
    end else if (!PAGE.in_cache) begin
      ext_pf = 1'b1; // R3
    end else if (OP_REQ.busy_map) begin
      ext_gp = 1'b1; // R5
    end else if (!PAGE.valid) begin
      ext_pf = 1'b1; // R3
    end else if (PAGE.ptype != EMI_PT_REGULAR && PAGE.ptype != EMI_PT_THREAD &&
                 PAGE.ptype != EMI_SHADOW_STACK_FIRST_TYPE && PAGE.ptype != EMI_SHADOW_STACK_REST_TYPE) begin
      ext_pf = 1'b1; // R4
    end else if (PAGE.owner != OP_REQ.op_b) begin
      ext_gp = 1'b1; // R6
    end else if (OP_REQ.busy_meas || OP_REQ.busy_init) begin
      ext_gp = 1'b1; // R5
    end else if (INITIALIZED) begin
      ext_gp = 1'b1; // R9 R23
    end
  end

  // ========================================================================
  // init outcome once the crypto unit answers
  logic attr_ctrl;
  always_comb begin
    next_code = EMI_ERR_NONE;
    next_gp = 1'b0;
    attr_ctrl = (PAGE.enclave_control_structure_attr & EMI_CTRL_ATTR) != 128'h0;
    if (!INIT_IN.struct_ok) begin
      next_code = EMI_ERR_STRUCT; // R22
    end else if (!CRYPTO.sig_ok) begin
      next_code = EMI_ERR_SIG; // R12
    end else if (req.busy_init || req.busy_meas) begin
      next_gp = 1'b1; // R5
    end else if (CRYPTO.final_meas != INIT_IN.hash) begin
      next_code = EMI_ERR_MEAS; // R13
    end else if (attr_ctrl && CRYPTO.signer != LAUNCH_KEY_HASH) begin
      next_code = EMI_ERR_ATTR; // R15
    end else if ((INIT_IN.attr & EMI_ATTR_RSVD) != 128'h0 ||
                 (~INIT_IN.mask & EMI_ATTR_RSVD) != 128'h0) begin
      next_code = EMI_ERR_ATTR; // R14
    end else if (attr_mismatch(INIT_IN.attr, INIT_IN.mask & PAGE.enclave_control_structure_attr)) begin
      next_code = EMI_ERR_ATTR; // R16
    end else if (!INIT_IN.tok_valid) begin
      if (CRYPTO.signer != LAUNCH_KEY_HASH) begin
        next_code = EMI_ERR_LICENSE; // R17
      end
    end else if (INIT_IN.tok_debug && !PAGE.enclave_control_structure_attr[EMI_DEBUG_BIT]) begin
      next_code = EMI_ERR_LICENSE; // R18
    end else if (!INIT_IN.tok_ok) begin
      next_code = EMI_ERR_LICENSE; // R18
    end else if (!INIT_IN.tok_ver_ok) begin
      next_code = EMI_ERR_VERSION; // R22
    end else if (INIT_IN.tok_meas != CRYPTO.final_meas) begin
      next_code = EMI_ERR_MEAS; // R18
    end
    next_err = next_code != EMI_ERR_NONE;
  end

  // init entry checks before crypto starts
  logic init_gp;
  logic init_pf;
  always_comb begin
    init_gp = !OP_REQ.addr_ok || misaligned(OP_REQ.op_b, EMI_ENCLAVE_CONTROL_STRUCTURE_ALIGN) ||
              misaligned(OP_REQ.op_c, EMI_ENCLAVE_CONTROL_STRUCTURE_ALIGN); // R10
    init_pf = !init_gp && !PAGE.in_cache;
    next_pf_addr = OP_REQ.op_c;
  end

  // two-flop sync: event lines arrive from outside the core clock domain
  // pending and inhibit share one latency so a masked event never slips through
  logic [5:0] evp_meta;
  logic [5:0] evp_sync;
  logic [5:0] evi_meta;
  logic [5:0] evi_sync;
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      evp_meta <= 6'h0;
      evp_sync <= 6'h0;
      evi_meta <= 6'h0;
      evi_sync <= 6'h0;
    end else begin
      evp_meta <= EVENT_PENDING;
      evp_sync <= evp_meta;
      evi_meta <= EVENT_INHIBIT;
      evi_sync <= evi_meta;
    end
  end

  // uninhibited asynchronous events abort the crypto window
  logic event_hit;
  always_comb begin
    event_hit = (evp_sync & ~evi_sync) != 6'h0; // R20
  end

  // ========================================================================
  // sequencing
  always_comb begin
    next_state = state;
    case (state)
      EMI_IDLE: begin
        if (OP_START && OP_REQ.leaf == EMI_LEAF_EXTEND && !ext_gp && !ext_pf) begin
          next_state = EMI_HDR;
        end else if (OP_START && OP_REQ.leaf == EMI_LEAF_INIT && !init_gp && !init_pf) begin
          next_state = EMI_INIT; // R11
        end
      end
      EMI_HDR: begin
        if (HASH_READY) begin
          next_state = EMI_BLK;
        end
      end
      EMI_BLK: begin
        if (HASH_READY && blk == EMI_LAST_BLK) begin
          next_state = EMI_IDLE;
        end
      end
      EMI_INIT: begin
        if (event_hit || CRYPTO_DONE) begin
          next_state = EMI_FIN;
        end
      end
      EMI_FIN: next_state = EMI_IDLE;
      default: next_state = EMI_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      state <= EMI_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // chunk block index, ascending address order
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      blk <= 2'h0;
    end else if (state == EMI_HDR) begin
      blk <= 2'h0;
    end else if (state == EMI_BLK && HASH_READY) begin
      blk <= blk + 2'h1; // R8
    end
  end

  // ========================================================================
  // hash stream: valid held until the engine takes the block
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      HASH_VALID <= 1'b0;
      HASH_BLOCK <= '0;
    end else if (next_state == EMI_HDR && state == EMI_IDLE) begin
      HASH_VALID <= 1'b1;
      HASH_BLOCK <= {384'h0, PAGE.encl_addr - PAGE.enclave_control_structure_base + (OP_REQ.op_c & EMI_PAGE_OFS),
                     EMI_EXT_TAG}; // R7
    end else if (state == EMI_HDR && HASH_READY) begin
      HASH_BLOCK <= CHUNK[511:0]; // R8
    end else if (state == EMI_BLK && HASH_READY) begin
      HASH_VALID <= blk != EMI_LAST_BLK;
      // last block taken: keep the word, no slice past the chunk's end
      if (blk != EMI_LAST_BLK) begin
        HASH_BLOCK <= CHUNK[{blk + 2'h1, 9'h000} +: 512]; // R8
      end
    end
  end

  // update counter moves only after hashing began, so faults leave it alone
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      UPDATE_COUNT <= 64'h0;
    end else if (state == EMI_HDR && HASH_READY) begin
      UPDATE_COUNT <= UPDATE_COUNT + EMI_HDR_INC; // R7 R24
    end else if (state == EMI_BLK && HASH_READY && blk == EMI_LAST_BLK) begin
      UPDATE_COUNT <= UPDATE_COUNT + EMI_CHUNK_INC; // R8
    end
  end

  // crypto request pulse at init start
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      CRYPTO_REQ <= 1'b0;
    end else begin
      CRYPTO_REQ <= state == EMI_IDLE && next_state == EMI_INIT; // R12
    end
  end

  // ========================================================================
  // identity commit, only on a clean finish
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      INITIALIZED <= 1'b0;
      MEAS_COMMIT <= 1'b0;
      SIGNER <= '0;
      SVN <= 16'h0;
      PRODID <= 16'h0;
    end else begin
      MEAS_COMMIT <= 1'b0;
      if (state == EMI_INIT && !event_hit && CRYPTO_DONE && !next_err && !next_gp) begin
        INITIALIZED <= 1'b1; // R19 R24
        MEAS_COMMIT <= 1'b1;
        SIGNER <= CRYPTO.signer;
        SVN <= INIT_IN.svn;
        PRODID <= INIT_IN.prodid;
      end
    end
  end

  // ========================================================================
  // completion, faults and flag reporting
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      OP_DONE <= 1'b0;
      GP_FAULT <= 1'b0;
      PF_FAULT <= 1'b0;
      PF_ADDR <= 64'h0;
      ARITH_CLEAR <= 1'b0;
      IP_ADVANCE <= 1'b0;
      ZERO_FLAG <= 1'b0;
      RESULT <= 64'h0;
    end else begin
      OP_DONE <= 1'b0;
      GP_FAULT <= 1'b0;
      PF_FAULT <= 1'b0;
      ARITH_CLEAR <= 1'b0;
      IP_ADVANCE <= 1'b0;
      if (state == EMI_IDLE && OP_START) begin
        if (OP_REQ.leaf == EMI_LEAF_EXTEND) begin
          GP_FAULT <= ext_gp;
          PF_FAULT <= ext_pf;
          OP_DONE <= ext_gp || ext_pf;
        end else if (OP_REQ.leaf == EMI_LEAF_INIT) begin
          GP_FAULT <= init_gp;
          PF_FAULT <= init_pf;
          OP_DONE <= init_gp || init_pf;
        end else begin
          GP_FAULT <= 1'b1; // unknown leaf refused
          OP_DONE <= 1'b1;
        end
        PF_ADDR <= next_pf_addr;
      end else if (state == EMI_BLK && HASH_READY && blk == EMI_LAST_BLK) begin
        OP_DONE <= 1'b1;
      end else if (state == EMI_INIT && event_hit) begin
        OP_DONE <= 1'b1;
        ARITH_CLEAR <= 1'b1; // R21
        IP_ADVANCE <= 1'b1; // R20
        ZERO_FLAG <= 1'b1;
        RESULT <= EMI_ERR_EVENT; // R20 R22
      end else if (state == EMI_INIT && CRYPTO_DONE) begin
        OP_DONE <= 1'b1;
        GP_FAULT <= next_gp; // R5
        ARITH_CLEAR <= !next_gp; // R21
        if (!next_gp) begin
          ZERO_FLAG <= next_err; // R21
          RESULT <= next_code; // R21 R22
        end
      end
    end
  end

  // busy spans hashing and the crypto wait; it is already low in EMI_FIN
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      BUSY <= 1'b0;
    end else begin
      BUSY <= next_state != EMI_IDLE && next_state != EMI_FIN;
    end
  end
endmodule

/* File: dv/emi_core_asserts.sv */
// emi_core_asserts: port-level checks on the measure/init sequencer
`timescale 1ns/10ps
module emi_core_asserts
  import emi_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic OP_START,
  input wire emi_req_s OP_REQ,
  input wire emi_page_s PAGE,
  input wire logic [2047:0] CHUNK,
  input wire logic HASH_READY,
  input wire logic CRYPTO_DONE,
  input wire logic BUSY,
  input wire logic OP_DONE,
  input wire logic GP_FAULT,
  input wire logic PF_FAULT,
  input wire logic [63:0] RESULT,
  input wire logic ZERO_FLAG,
  input wire logic ARITH_CLEAR,
  input wire logic HASH_VALID,
  input wire logic [511:0] HASH_BLOCK,
  input wire logic MEAS_COMMIT,
  input wire logic INITIALIZED,
  input wire logic [63:0] UPDATE_COUNT
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RESETN);
  // ========================================================================
  // extend taken while idle, in a legal mode and at level 0
  wire ext = OP_START && !BUSY && OP_REQ.leaf == EMI_LEAF_EXTEND && OP_REQ.addr_ok
    && OP_REQ.cpl == EMI_CPL0;
  sb_align_a: assert property (ext && OP_REQ.op_b[11:0] != 12'h000 |=> OP_DONE && GP_FAULT)
    else $error("misaligned control address not refused");
  fault_frozen_a: assert property (GP_FAULT || PF_FAULT |->
    $stable(UPDATE_COUNT) && $stable(INITIALIZED))
    else $error("fault changed measurement state");
  hdr_block_a: assert property ($rose(HASH_VALID) |-> HASH_BLOCK[63:0] == EMI_EXT_TAG
    && HASH_BLOCK[511:128] == 384'h0 && HASH_BLOCK[127:64] == PAGE.encl_addr
    - PAGE.enclave_control_structure_base + (OP_REQ.op_c & EMI_PAGE_OFS)) else $error("bad header block");
  hdr_count_a: assert property ($rose(HASH_VALID) && HASH_READY |=> HASH_VALID
    && HASH_BLOCK == CHUNK[511:0] && UPDATE_COUNT == $past(UPDATE_COUNT) + EMI_HDR_INC)
    else $error("header step wrong");
  chunk_count_a: assert property ($fell(HASH_VALID) |-> OP_DONE
    && UPDATE_COUNT == $past(UPDATE_COUNT) + EMI_CHUNK_INC) else $error("chunk count wrong");
  init_ok_a: assert property (MEAS_COMMIT |-> INITIALIZED && !ZERO_FLAG
    && RESULT == EMI_ERR_NONE) else $error("success report wrong");
  init_err_a: assert property (ARITH_CLEAR && !MEAS_COMMIT |-> ZERO_FLAG
    && RESULT != EMI_ERR_NONE) else $error("error report wrong");
  init_end_a: assert property (BUSY && CRYPTO_DONE |=> OP_DONE && (ARITH_CLEAR || GP_FAULT))
    else $error("init did not end after crypto answer");
endmodule
bind emi_core emi_core_asserts i_chk (.*);

/* File: dv/emi_partner.sv */
// emi_partner: hash engine and crypto unit facing the sequencer
`timescale 1ns/10ps
module emi_partner
  import emi_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic STALL,
  input wire logic CRYPTO_REQ,
  input wire emi_crypto_s CRY_VAL,
  output logic HASH_READY,
  output logic CRYPTO_DONE,
  output emi_crypto_s CRYPTO
);
  logic [3:0] wait_cnt;
  // ========================================================================
  // hash engine takes a block unless stalled
  assign HASH_READY = !STALL;
  // results are only valid in the answer cycle; junk otherwise
  assign CRYPTO = CRYPTO_DONE ? CRY_VAL : ~CRY_VAL;
  // crypto answers ten cycles after a request, slow enough to poll events
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      wait_cnt <= 4'h0;
      CRYPTO_DONE <= 1'b0;
    end else begin
      CRYPTO_DONE <= wait_cnt == 4'h1;
      wait_cnt <= CRYPTO_REQ ? 4'h9 : wait_cnt - {3'h0, wait_cnt != 4'h0};
    end
  end
endmodule

/* File: dv/emi_core_tb_top.sv */
// emi_core_tb_top: self-checking bench for the measure/init sequencer
`timescale 1ns/10ps
module emi_core_tb_top
  import emi_pkg::*;
;
  localparam logic [63:0] SB = 64'h0000_0000_0004_0000;
  localparam logic [63:0] CH = 64'h0000_0000_0002_1300;
  logic clk, rstn, start, stall, crq, cdone, hrdy, busy, done, gp, pf, zf, ac, hv, mc, ini;
  logic [5:0] evp, evi;
  logic ipa;
  logic [15:0] svn, pid;
  logic [63:0] pfa;
  logic [63:0] res, cnt, ecnt, b, c, leaf, e;
  logic [255:0] h, k, key, sgn;
  logic [2047:0] chunk;
  logic [511:0] hb;
  logic [132:0] n, s;
  logic [132:0] q[$];
  logic [7:0] pt[4] = '{EMI_PT_REGULAR, EMI_PT_THREAD, EMI_SHADOW_STACK_FIRST_TYPE, EMI_SHADOW_STACK_REST_TYPE};
  logic [4:0] f;
  emi_req_s req;
  emi_page_s pg;
  emi_init_s iin;
  emi_crypto_s cv, cry;
  int seed = 32'h79b9077c;
  int err_count = 0;
  int check_count = 0;
  int i, j, w;

  emi_core i_dut (.CLOCK(clk), .RESETN(rstn), .OP_START(start), .OP_REQ(req), .PAGE(pg),
    .INIT_IN(iin), .CHUNK(chunk), .LAUNCH_KEY_HASH(key), .EVENT_PENDING(evp),
    .EVENT_INHIBIT(evi), .HASH_READY(hrdy), .CRYPTO_DONE(cdone), .CRYPTO(cry), .BUSY(busy),
    .OP_DONE(done), .GP_FAULT(gp), .PF_FAULT(pf), .PF_ADDR(pfa), .RESULT(res), .ZERO_FLAG(zf),
    .ARITH_CLEAR(ac), .IP_ADVANCE(ipa), .HASH_VALID(hv), .HASH_BLOCK(hb), .CRYPTO_REQ(crq),
    .MEAS_COMMIT(mc), .INITIALIZED(ini), .UPDATE_COUNT(cnt), .SIGNER(sgn),
    .SVN(svn), .PRODID(pid));
  emi_partner i_partner (.CLOCK(clk), .RESETN(rstn), .STALL(stall), .CRYPTO_REQ(crq),
    .CRY_VAL(cv), .HASH_READY(hrdy), .CRYPTO_DONE(cdone), .CRYPTO(cry));

  // ========================================================================
  // clock, and a hash engine that stalls about one cycle in four
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    #1;
    stall = ($random(seed) & 3) == 0;
  end

  task automatic chk(input logic [255:0] seen, input logic [255:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // a clean enclave with a good, self-signed structure and no events
  task automatic dflt();
    req = '0;
    req.addr_ok = 1'b1;
    pg = '{1'b1, 1'b1, EMI_PT_REGULAR, SB, 64'h7000, 64'h1000, 128'h0};
    iin = '{1'b1, 128'h0, '1, h, 16'h0003, 16'h0002, 1'b0, 1'b1, 1'b1, 1'b0, h};
    cv = '{1'b1, h, k};
    evp = 6'h00;
    evi = 6'h00;
  endtask

  // one operation; the note is left for the completion watcher
  task automatic op(input logic [63:0] lf, bb, cc, input logic [4:0] ff, input logic [63:0] r);
    int t;
    @(posedge clk);
    #1;
    req.leaf = lf;
    req.op_b = bb;
    req.op_c = cc;
    start = 1'b1;
    q.push_back({ff, r, ecnt});
    @(posedge clk);
    #1;
    start = 1'b0;
    for (t = 0; t < 200 && done !== 1'b1; t++) begin
      @(posedge clk);
      #1;
    end
    if (t == 200) begin
      err_count++;
      finish_test();
    end
    @(posedge clk); // init needs one idle cycle after it ends
    #1;
  endtask

  // compare each completion with the oldest note; result only for init
  always @(posedge clk) begin
    if (done === 1'b1 && q.size() > 0) begin
      n = q.pop_front();
      s = {n[132], gp, pf, ini, n[132] ? zf : n[128], n[132] ? res : n[127:64], cnt};
      chk(s, n);
      if (n[132] && !n[131]) chk(ipa, n[127:64] == EMI_ERR_EVENT);
      if (n[130]) chk(pfa, req.op_c);
    end
  end

  initial begin
    rstn = 1'b0;
    start = 1'b0;
    chunk = '0;
    ecnt = 64'h0;
    h = {8{$random(seed)}};
    k = {8{$random(seed)}};
    key = k;
    dflt();
    repeat (6) @(posedge clk);
    #1;
    rstn = 1'b1;
    // extend refusals, none of which may touch the count
    for (i = 0; i < 12; i++) begin
      dflt();
      {b, c, leaf, f} = {SB, CH, EMI_LEAF_EXTEND, 5'b01000};
      case (i)
        0: b = SB + 64'h800;
        1: c = CH + 64'h40;
        2: {pg.in_cache, f} = {1'b0, 5'b00100};
        3: {pg.valid, f} = {1'b0, 5'b00100};
        4: {pg.ptype, f} = {8'h03, 5'b00100};
        5: req.busy_map = 1'b1;
        6: pg.owner = SB + 64'h1000;
        7: req.addr_ok = 1'b0;
        8: req.cpl = 2'h3;
        9: req.busy_meas = 1'b1;
        10: req.busy_init = 1'b1;
        default: leaf = 64'h0000_0000_0000_0011;
      endcase
      op(leaf, b, c, f, 64'h0);
    end
    $display("extend refusal test done");
    // good extends on every accepted page type, each started after the previous one completes
    for (i = 0; i < 4; i++) begin
      dflt();
      pg.ptype = pt[i];
      for (w = 0; w < 64; w++) chunk[w*32 +: 32] = $random(seed);
      ecnt = ecnt + 64'h5;
      op(EMI_LEAF_EXTEND, SB, CH + 64'(i) * 64'h100, 5'b00000, 64'h0);
    end
    $display("extend measure test done");
    // every init failure kind leaves the enclave uninitialized
    for (j = 0; j < 12; j++) begin
      dflt();
      case (j)
        0: {iin.struct_ok, e} = {1'b0, EMI_ERR_STRUCT};
        1: {cv.sig_ok, e} = {1'b0, EMI_ERR_SIG};
        2: {iin.hash, e} = {~h, EMI_ERR_MEAS};
        3: {iin.attr, pg.enclave_control_structure_attr, cv.signer, e} = {EMI_CTRL_ATTR, EMI_CTRL_ATTR, ~k, EMI_ERR_ATTR};
        4: {iin.attr[63], e} = {1'b1, EMI_ERR_ATTR};
        5: {pg.enclave_control_structure_attr[1], e} = {1'b1, EMI_ERR_ATTR};
        6: {cv.signer, e} = {~k, EMI_ERR_LICENSE};
        7: {iin.tok_valid, iin.tok_debug, e} = {2'b11, EMI_ERR_LICENSE};
        8: {iin.tok_valid, iin.tok_ver_ok, e} = {2'b10, EMI_ERR_VERSION};
        9: {iin.tok_valid, iin.tok_meas, e} = {1'b1, ~h, EMI_ERR_MEAS};
        10: {evp, e} = {6'h01, EMI_ERR_EVENT};
        // conflict faults with no report: result and flag stay from the event case
        default: {req.busy_init, e} = {1'b1, EMI_ERR_EVENT};
      endcase
      op(EMI_LEAF_INIT, 64'h0009_0000, SB, {1'b1, j == 11, 3'b001}, e);
    end
    // inhibited events must not stop a good init
    dflt();
    {evp, evi, iin.tok_valid} = {6'h3f, 6'h3f, 1'b1};
    op(EMI_LEAF_INIT, 64'h0009_0000, SB, 5'b10010, EMI_ERR_NONE);
    chk(sgn, k);
    chk({svn, pid}, {16'h0003, 16'h0002});
    // an initialized enclave refuses further measurement
    dflt();
    op(EMI_LEAF_EXTEND, SB, CH, 5'b01010, 64'h0);
    $display("enclave init test done");
    finish_test();
  end
endmodule
